// ---- dv/dms_sig_src.sv ----
// Far-side model of the enable, direction, clock and analog sources
`timescale 1ns/10ps
module dms_sig_src (
    input wire logic ref_clk,
    input wire logic en_req,
    input wire logic dir_req,
    input wire logic step_go,
    input wire logic [11:0] code_req,
    output logic enable_in,
    output logic dir_in,
    output logic step_in,
    output logic [11:0] adc_data,
    output logic adc_valid
);
    logic [5:0] tick_r;
    initial begin
        tick_r = 6'h00;
        enable_in = 1'b0;
        dir_in = 1'b0;
        step_in = 1'b0;
        adc_data = 12'h000;
        adc_valid = 1'b0;
    end
    always @(posedge ref_clk) begin
        tick_r <= tick_r + 6'h01;
        enable_in <= en_req;
        dir_in <= dir_req;
        // Clock line stands still outside bursts
        step_in <= step_go ? tick_r[2] : 1'b0;
        adc_valid <= (tick_r == 6'h3F);
        // Between samples the bus carries junk, so a stale code is never reused
        adc_data <= (tick_r == 6'h3F) ? code_req : ~code_req;
    end
endmodule

// ---- dv/dms_top_tb_top.sv ----
// Self-checking bench for the drive mode selector
`timescale 1ns/10ps
`include "dms_map.svh"
module dms_top_tb_top import dms_pkg::*;;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] dip_sw = 4'h2;
    logic en_req = 1'b0;
    logic dir_req = 1'b0;
    logic step_go = 1'b0;
    logic [11:0] code_req = 12'h000;
    logic enable_in, dir_in, step_in, adc_valid, closed_loop, user_prog_start;
    logic step_pulse, step_dir, prev_step;
    logic [11:0] adc_data;
    dms_obj_wr_type obj_wr;
    dms_mode_type op_mode;
    logic signed [31:0] target_vel;
    logic [31:0] q;
    dms_obj_wr_type wq[$];
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int last_wr = 0;
    int n_pulse = 0;
    int n_edge = 0;
    always #2 ref_clk = ~ref_clk;
    dms_top u_dms_top (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dip_sw(dip_sw), .enable_in(enable_in), .dir_in(dir_in), .step_in(step_in),
        .adc_data(adc_data), .adc_valid(adc_valid), .obj_wr(obj_wr), .op_mode(op_mode),
        .closed_loop(closed_loop), .user_prog_start(user_prog_start), .step_pulse(step_pulse),
        .step_dir(step_dir), .target_vel(target_vel));
    dms_sig_src u_dms_sig_src (.ref_clk(ref_clk), .en_req(en_req), .dir_req(dir_req),
        .step_go(step_go), .code_req(code_req), .enable_in(enable_in), .dir_in(dir_in),
        .step_in(step_in), .adc_data(adc_data), .adc_valid(adc_valid));
    task automatic close_out();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic entry(input logic [3:0] i, input logic [15:0] ix, input logic [7:0] sb,
            input logic cm, input logic [31:0] v);
        bus(1'b1, `DMS_OFS_TBL_ADDR, {28'h0, i});
        bus(1'b1, `DMS_OFS_TBL_OBJ, {ix, sb, 7'h00, cm});
        bus(1'b1, `DMS_OFS_TBL_VAL, v);
    endtask
    task automatic restart(input logic [3:0] sw);
        int n;
        dip_sw <= sw;
        wq.delete();
        bus(1'b1, `DMS_OFS_CTRL, 32'h1);
        n = 0;
        while (user_prog_start !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk("start_order", (wq.size() == 0 || last_wr < cyc) && n < 400, 1);
        @(posedge ref_clk);
    endtask
    // Bounded wait for the speed to settle, then compare
    task automatic vel(input logic [11:0] code, input logic dir, input logic en,
            input logic [31:0] exp);
        int n;
        code_req <= code;
        dir_req <= dir;
        en_req <= en;
        n = 0;
        repeat (8) @(posedge ref_clk);
        while (target_vel !== exp && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        chk("target_vel", target_vel, exp);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
        if (obj_wr.valid === 1'b1) begin
            wq.push_back(obj_wr);
            last_wr = cyc;
        end
        if (step_pulse === 1'b1) n_pulse++;
        if (step_in === 1'b1 && prev_step === 1'b0) n_edge++;
        prev_step <= step_in;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("mode_test", op_mode, DMS_MODE_TEST);
        vel(12'h000, 1'b0, 1'b1, 32'd30);
        vel(12'h000, 1'b0, 1'b0, 32'd0);
        entry(4'h0, `DMS_OBJ_SCALE, `DMS_SUB_NUM, 1'b1, 32'h7);
        entry(4'h1, `DMS_OBJ_SCALE, `DMS_SUB_NUM, 1'b0, 32'h5);
        entry(4'h2, `DMS_OBJ_SCALE, `DMS_SUB_NUM, 1'b0, 32'h2);
        entry(4'h3, `DMS_OBJ_SCALE, `DMS_SUB_DEN, 1'b0, 32'h1);
        bus(1'b1, `DMS_OFS_TBL_CNT, 32'h4);
        restart(4'h9);
        chk("obj_count", wq.size(), 3);
        chk("obj_first", wq[0].value, 32'h5);
        chk("obj_last", {wq[2].index, wq[2].sub}, {`DMS_OBJ_SCALE, `DMS_SUB_DEN});
        bus(1'b0, `DMS_OFS_SCALE, 32'h0);
        chk("scale", q, 32'h0001_0002);
        chk("closed", closed_loop, 1'b1);
        chk("mode_an", op_mode, DMS_MODE_ANALOG);
        vel(12'hFFF, 1'b0, 1'b1, 32'd2000);
        vel(12'hFFF, 1'b1, 1'b1, -32'sd2000);
        vel(12'h008, 1'b0, 1'b1, 32'd0);
        entry(4'h3, `DMS_OBJ_SCALE, `DMS_SUB_DEN, 1'b0, 32'h2);
        bus(1'b0, `DMS_OFS_SCALE, 32'h0);
        chk("scale_run", q, 32'h0001_0002);
        restart(4'h7);
        chk("open", closed_loop, 1'b0);
        vel(12'hFFF, 1'b0, 1'b1, 32'd100);
        vel(12'h000, 1'b0, 1'b1, -32'sd100);
        vel(12'h808, 1'b0, 1'b1, 32'd0);
        restart(4'h6);
        vel(12'h000, 1'b0, 1'b1, -32'sd30);
        restart(4'h0);
        en_req <= 1'b0;
        step_go <= 1'b1;
        repeat (100) @(posedge ref_clk);
        chk("step_off", n_pulse, 0);
        // Counters cleared while the clock line is quiet, so no edge straddles the clear
        en_req <= 1'b1;
        dir_req <= 1'b1;
        step_go <= 1'b0;
        repeat (10) @(posedge ref_clk);
        n_pulse = 0;
        n_edge = 0;
        step_go <= 1'b1;
        repeat (100) @(posedge ref_clk);
        step_go <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk("step_on", n_pulse, n_edge);
        chk("step_dir", step_dir, 1'b1);
        entry(4'h4, `DMS_OBJ_SWDIS, `DMS_SUB_ZERO, 1'b0, 32'h1);
        bus(1'b1, `DMS_OFS_TBL_CNT, 32'h5);
        restart(4'h2);
        chk("mode_off", op_mode, DMS_MODE_NONE);
        bus(1'b0, `DMS_OFS_STATUS, 32'h0);
        chk("swdis", q[7], 1'b1);
        bus(1'b0, 5'h01, 32'h0);
        chk("unmapped", q, 32'h0);
        close_out();
    end
endmodule

// ---- rtl/dms_div.sv ----
// Sequential restoring divider for speed scaling, one quotient bit per cycle
`timescale 1ns/10ps
`include "dms_map.svh"
module dms_div (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [39:0] num,
    input wire logic [27:0] den,
    output logic busy,
    output logic done,
    output logic [39:0] quo
);
    logic [39:0] quo_nxt, rem_r, rem_nxt;
    logic [27:0] den_r, den_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic busy_nxt, done_nxt;
    logic [40:0] trial;

    always_comb begin
        quo_nxt = quo;
        rem_nxt = rem_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy;
        done_nxt = 1'b0;
        trial = '0;
        if (start && !busy) begin
            quo_nxt = num;
            rem_nxt = '0;
            den_nxt = den;
            cnt_nxt = `DMS_DIV_STEPS;
            busy_nxt = 1'b1;
        end else if (busy) begin
            trial = {rem_r, quo[39]} - {13'h0, den_r};
            if (!trial[40]) begin
                rem_nxt = trial[39:0];
                quo_nxt = {quo[38:0], 1'b1};
            end else begin
                rem_nxt = {rem_r[38:0], quo[39]};
                quo_nxt = {quo[38:0], 1'b0};
            end
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            quo <= '0;
            rem_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            quo <= quo_nxt;
            rem_r <= rem_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
            busy <= busy_nxt;
            done <= done_nxt;
        end
    end
endmodule

// ---- rtl/dms_map.svh ----
// Register offsets, object codes and fixed figures of the drive mode selector
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH

`define DMS_OFS_STATUS 5'h00
`define DMS_OFS_CTRL 5'h04
`define DMS_OFS_TBL_ADDR 5'h08
`define DMS_OFS_TBL_OBJ 5'h0C
`define DMS_OFS_TBL_VAL 5'h10
`define DMS_OFS_TBL_CNT 5'h14
`define DMS_OFS_TVEL 5'h18
`define DMS_OFS_SCALE 5'h1C

`define DMS_TBL_DEPTH 16
`define DMS_TBL_AW 4
`define DMS_CTRL_RESTART 0
`define DMS_OBJ_COMMENT 0

`define DMS_OBJ_SWDIS 16'hDD4C
`define DMS_OBJ_TVEL 16'h6042
`define DMS_OBJ_SCALE 16'h604C
`define DMS_SUB_ZERO 8'h00
`define DMS_SUB_NUM 8'h01
`define DMS_SUB_DEN 8'h02
`define DMS_SCALE_RST 16'h0001

`define DMS_RPM_TEST 11'h01E
`define DMS_RPM_HIGH 11'h3E8
`define DMS_RPM_LOW 11'h064

`define DMS_ADC_SPAN 12'hFFF
`define DMS_ADC_MID 12'h800
`define DMS_ADC_HALF 12'h7FF
`define DMS_FULL_MV 10000
`define DMS_DEAD_MV 20
`define DMS_DEAD_CODE 12'((`DMS_DEAD_MV * 4095) / `DMS_FULL_MV)
`define DMS_SETTLE 2'h3
`define DMS_DIV_STEPS 6'h28

`endif

// ---- rtl/dms_pkg.sv ----
// Types shared by the drive mode selector files
package dms_pkg;
    typedef enum logic [2:0] {
        DMS_MODE_NONE, DMS_MODE_CLKDIR, DMS_MODE_TEST, DMS_MODE_ANALOG, DMS_MODE_JOY
    } dms_mode_type;

    typedef enum logic [1:0] {DMS_ST_APPLY, DMS_ST_SWITCH, DMS_ST_START, DMS_ST_RUN} dms_state_type;

    typedef struct packed {
        logic comment;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] value;
    } dms_entry_type;

    typedef struct packed {
        logic valid;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] value;
    } dms_obj_wr_type;
endpackage

// ---- rtl/dms_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dms_sync #(parameter int W = 1) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// ---- rtl/dms_top.sv ----
// Start-up configuration and special drive mode selection with analog speed command
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`include "dms_map.svh"
module dms_top import dms_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] dip_sw,
    input wire logic enable_in,
    input wire logic dir_in,
    input wire logic step_in,
    input wire logic [11:0] adc_data,
    input wire logic adc_valid,
    output dms_obj_wr_type obj_wr,
    output dms_mode_type op_mode,
    output logic closed_loop,
    output logic user_prog_start,
    output logic step_pulse,
    output logic step_dir,
    output logic signed [31:0] target_vel
);
    dms_entry_type tbl [`DMS_TBL_DEPTH];
    logic [3:0] sw_s;
    logic en_s, dir_s, step_s;

    dms_sync #(.W(4)) u_sw_sync (.ref_clk(ref_clk), .reset(reset), .din(dip_sw), .dout(sw_s));
    dms_sync #(.W(3)) u_io_sync (.ref_clk(ref_clk), .reset(reset),
        .din({enable_in, dir_in, step_in}), .dout({en_s, dir_s, step_s}));

    // Bus slave: one wait cycle, then one cycle with waitrequest low
    logic [`DMS_TBL_AW-1:0] tbl_addr_r, tbl_addr_nxt;
    dms_entry_type tbl_obj_r, tbl_obj_nxt;
    logic [`DMS_TBL_AW:0] tbl_cnt_r, tbl_cnt_nxt;
    logic restart_r, restart_nxt;
    logic [31:0] rdata_nxt, wmask;
    logic wait_nxt, bus_req, bus_go, tbl_we;
    dms_state_type state_r, state_nxt;
    logic swdis_r;
    logic [15:0] scale_num_r, scale_den_r;

    assign bus_req = avs_read || avs_write;
    assign bus_go = bus_req && !avs_waitrequest;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always_comb begin
        tbl_addr_nxt = tbl_addr_r;
        tbl_obj_nxt = tbl_obj_r;
        tbl_cnt_nxt = tbl_cnt_r;
        restart_nxt = 1'b0;
        tbl_we = 1'b0;
        wait_nxt = !(bus_req && avs_waitrequest);
        rdata_nxt = avs_readdata;
        if (bus_req && avs_waitrequest) begin
            unique case (avs_address)
                `DMS_OFS_STATUS: rdata_nxt = {22'h0, state_r, swdis_r, en_s,
                                              closed_loop, 2'h0, op_mode};
                `DMS_OFS_TBL_ADDR: rdata_nxt = {28'h0000000, tbl_addr_r};
                `DMS_OFS_TBL_OBJ: rdata_nxt = {tbl_obj_r.index, tbl_obj_r.sub,
                                               7'h00, tbl_obj_r.comment};
                `DMS_OFS_TBL_CNT: rdata_nxt = {27'h0, tbl_cnt_r};
                `DMS_OFS_TVEL: rdata_nxt = target_vel;
                `DMS_OFS_SCALE: rdata_nxt = {scale_den_r, scale_num_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        // Writes land on the edge where waitrequest is seen low
        if (bus_go && avs_write) begin
            unique case (avs_address)
                `DMS_OFS_CTRL: restart_nxt = avs_writedata[`DMS_CTRL_RESTART]
                                             && avs_byteenable[0];
                `DMS_OFS_TBL_ADDR: if (avs_byteenable[0]) begin
                    tbl_addr_nxt = avs_writedata[`DMS_TBL_AW-1:0];
                end
                `DMS_OFS_TBL_OBJ: begin
                    tbl_obj_nxt.comment = avs_byteenable[0] ?
                        avs_writedata[`DMS_OBJ_COMMENT] : tbl_obj_r.comment;
                    {tbl_obj_nxt.index, tbl_obj_nxt.sub} =
                        ({tbl_obj_r.index, tbl_obj_r.sub} & ~wmask[31:8]) |
                        (avs_writedata[31:8] & wmask[31:8]);
                end
                `DMS_OFS_TBL_VAL: begin
                    tbl_obj_nxt.value = (tbl_obj_r.value & ~wmask) | (avs_writedata & wmask);
                    tbl_we = 1'b1;
                end
                `DMS_OFS_TBL_CNT: if (avs_byteenable[0]) begin
                    tbl_cnt_nxt = avs_writedata[`DMS_TBL_AW:0];
                end
                default: ;
            endcase
        end
    end

    // Store is not reset: it survives restarts like a stored file
    always_ff @(posedge ref_clk) begin
        if (tbl_we) begin
            tbl[tbl_addr_r] <= tbl_obj_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tbl_addr_r <= '0;
            tbl_obj_r <= '0;
            tbl_cnt_r <= '0;
            restart_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            tbl_addr_r <= tbl_addr_nxt;
            tbl_obj_r <= tbl_obj_nxt;
            tbl_cnt_r <= tbl_cnt_nxt;
            restart_r <= restart_nxt;
            avs_waitrequest <= wait_nxt;
            avs_readdata <= rdata_nxt;
        end
    end

    // Start-up sequencer
    logic [`DMS_TBL_AW:0] idx_r, idx_nxt;
    logic [1:0] settle_r, settle_nxt;
    logic swdis_nxt, closed_nxt, start_nxt;
    logic [15:0] scale_num_nxt, scale_den_nxt;
    dms_mode_type mode_nxt;
    dms_obj_wr_type obj_nxt;
    dms_entry_type ent;
    logic [10:0] max_rpm_r, max_rpm_nxt;
    logic test_neg_r, test_neg_nxt;

    assign ent = tbl[idx_r[`DMS_TBL_AW-1:0]];

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        settle_nxt = settle_r;
        swdis_nxt = swdis_r;
        scale_num_nxt = scale_num_r;
        scale_den_nxt = scale_den_r;
        mode_nxt = op_mode;
        closed_nxt = closed_loop;
        max_rpm_nxt = max_rpm_r;
        test_neg_nxt = test_neg_r;
        start_nxt = 1'b0;
        obj_nxt = '0;
        unique case (state_r)
            DMS_ST_APPLY: begin
                if (idx_r < tbl_cnt_r) begin
                    if (!ent.comment) begin
                        obj_nxt = {1'b1, ent.index, ent.sub, ent.value};
                        if (ent.index == `DMS_OBJ_SWDIS && ent.sub == `DMS_SUB_ZERO) begin
                            swdis_nxt = ent.value == 32'h00000001;
                        end
                        if (ent.index == `DMS_OBJ_SCALE && ent.sub == `DMS_SUB_NUM) begin
                            scale_num_nxt = ent.value[15:0];
                        end
                        if (ent.index == `DMS_OBJ_SCALE && ent.sub == `DMS_SUB_DEN) begin
                            scale_den_nxt = ent.value[15:0];
                        end
                    end
                    idx_nxt = idx_r + 1'b1;
                end else begin
                    state_nxt = DMS_ST_SWITCH;
                end
            end
            DMS_ST_SWITCH: begin
                // Wait for the switch synchroniser to hold settled samples
                settle_nxt = settle_r + 2'h1;
                if (settle_r == `DMS_SETTLE) begin
                    state_nxt = DMS_ST_START;
                    if (swdis_r) begin
                        mode_nxt = DMS_MODE_NONE;
                    end else begin
                        closed_nxt = sw_s[3];
                        test_neg_nxt = sw_s[2];
                        max_rpm_nxt = sw_s[2] ? `DMS_RPM_LOW : `DMS_RPM_HIGH;
                        if (sw_s[0]) begin
                            mode_nxt = sw_s[1] ? DMS_MODE_JOY : DMS_MODE_ANALOG;
                        end else begin
                            mode_nxt = sw_s[1] ? DMS_MODE_TEST : DMS_MODE_CLKDIR;
                        end
                    end
                end
            end
            DMS_ST_START: begin
                start_nxt = 1'b1;
                state_nxt = DMS_ST_RUN;
            end
            DMS_ST_RUN: ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset || restart_r) begin
            state_r <= DMS_ST_APPLY;
            idx_r <= '0;
            settle_r <= 2'h0;
            swdis_r <= 1'b0;
            scale_num_r <= `DMS_SCALE_RST;
            scale_den_r <= `DMS_SCALE_RST;
            op_mode <= DMS_MODE_NONE;
            closed_loop <= 1'b0;
            max_rpm_r <= `DMS_RPM_HIGH;
            test_neg_r <= 1'b0;
            user_prog_start <= 1'b0;
            obj_wr <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            settle_r <= settle_nxt;
            swdis_r <= swdis_nxt;
            scale_num_r <= scale_num_nxt;
            scale_den_r <= scale_den_nxt;
            op_mode <= mode_nxt;
            closed_loop <= closed_nxt;
            max_rpm_r <= max_rpm_nxt;
            test_neg_r <= test_neg_nxt;
            user_prog_start <= start_nxt;
            obj_wr <= obj_nxt;
        end
    end

    // Motion: clock-direction steps, test run and analog speed
    logic running, joy, dead, neg_now, neg_r, neg_nxt, step_prev_r;
    logic step_pulse_nxt, step_dir_nxt, div_start, div_busy, div_done;
    logic [11:0] mag, span;
    logic [39:0] div_q;
    logic signed [31:0] vel_nxt;

    assign running = state_r == DMS_ST_RUN;
    assign joy = op_mode == DMS_MODE_JOY;
    assign mag = joy ? (adc_data >= `DMS_ADC_MID ? adc_data - `DMS_ADC_MID
                                                  : `DMS_ADC_MID - adc_data) : adc_data;
    assign span = joy ? `DMS_ADC_HALF : `DMS_ADC_SPAN;
    assign dead = mag <= `DMS_DEAD_CODE;
    assign neg_now = joy ? adc_data < `DMS_ADC_MID : dir_s;
    assign div_start = running && en_s && adc_valid && !div_busy && !dead &&
                       (op_mode == DMS_MODE_ANALOG || joy);

    // ADC magnitude times max rpm times scaling ratio, over the span
    dms_div u_div (.ref_clk(ref_clk), .reset(reset), .start(div_start),
        .num(40'(mag * max_rpm_r * scale_num_r)), .den(28'(span * scale_den_r)),
        .busy(div_busy), .done(div_done), .quo(div_q));

    always_comb begin
        vel_nxt = target_vel;
        neg_nxt = div_start ? neg_now : neg_r;
        step_pulse_nxt = 1'b0;
        step_dir_nxt = step_dir;
        if (!running || !en_s) begin
            vel_nxt = 32'sh00000000;
        end else begin
            unique case (op_mode)
                DMS_MODE_CLKDIR: begin
                    step_pulse_nxt = step_s && !step_prev_r;
                    step_dir_nxt = dir_s;
                end
                DMS_MODE_TEST: vel_nxt = test_neg_r ? -32'(`DMS_RPM_TEST)
                                                    : 32'(`DMS_RPM_TEST);
                DMS_MODE_ANALOG, DMS_MODE_JOY: begin
                    if (adc_valid && !div_busy && dead) begin
                        vel_nxt = 32'sh00000000;
                    end else if (div_done) begin
                        vel_nxt = neg_r ? -$signed({1'b0, div_q[30:0]})
                                        : $signed({1'b0, div_q[30:0]});
                    end
                end
                default: vel_nxt = 32'sh00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || restart_r) begin
            target_vel <= 32'sh00000000;
            neg_r <= 1'b0;
            step_prev_r <= 1'b0;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
        end else begin
            target_vel <= vel_nxt;
            neg_r <= neg_nxt;
            step_prev_r <= step_s;
            step_pulse <= step_pulse_nxt;
            step_dir <= step_dir_nxt;
        end
    end

    property p_order;
        @(posedge ref_clk) disable iff (reset) user_prog_start |-> $past(state_r, 2) == DMS_ST_SWITCH;
    endproperty
    a_order: assert property (p_order) else $error("user program started out of order");

    property p_seq;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (state_r == DMS_ST_APPLY && idx_r < tbl_cnt_r) |=> idx_r == $past(idx_r) + 1'b1;
    endproperty
    a_seq: assert property (p_seq) else $error("entries not walked in order");

    property p_comment;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (state_r == DMS_ST_APPLY && idx_r < tbl_cnt_r && ent.comment) |=> !obj_wr.valid;
    endproperty
    a_comment: assert property (p_comment) else $error("comment entry had an effect");

    property p_swdis;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (state_r == DMS_ST_SWITCH && settle_r == `DMS_SETTLE && swdis_r)
        |=> op_mode == DMS_MODE_NONE && !closed_loop;
    endproperty
    a_swdis: assert property (p_swdis) else $error("switches used while disabled");

    property p_clkdir;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (state_r == DMS_ST_SWITCH && settle_r == `DMS_SETTLE && !swdis_r && !sw_s[0] && !sw_s[1])
        |=> op_mode == DMS_MODE_CLKDIR ##1 user_prog_start;
    endproperty
    a_clkdir: assert property (p_clkdir) else $error("switch decode wrong");

    property p_loop;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (state_r == DMS_ST_SWITCH && settle_r == `DMS_SETTLE && !swdis_r)
        |=> closed_loop == $past(sw_s[3]);
    endproperty
    a_loop: assert property (p_loop) else $error("loop select wrong");

    property p_test;
        @(posedge ref_clk) disable iff (reset || restart_r)
        // Restart clears the speed one edge later, so that edge is excluded
        (running && !restart_r && op_mode == DMS_MODE_TEST && en_s)
        |=> target_vel == (test_neg_r ? -32'sd30 : 32'sd30);
    endproperty
    a_test: assert property (p_test) else $error("test run speed wrong");

    property p_disable;
        @(posedge ref_clk) disable iff (reset || restart_r)
        !en_s |=> target_vel == 32'sh00000000 && !step_pulse;
    endproperty
    a_disable: assert property (p_disable) else $error("motion while enable low");

    property p_dead;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (running && !restart_r && en_s && adc_valid && !div_busy && dead &&
         (op_mode == DMS_MODE_ANALOG || joy)) |=> target_vel == 32'sh00000000;
    endproperty
    a_dead: assert property (p_dead) else $error("dead zone gave speed");

    property p_freeze;
        @(posedge ref_clk) disable iff (reset || restart_r)
        (running && !restart_r)
        |=> $stable(op_mode) && $stable(closed_loop) && $stable(scale_num_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("configuration changed while running");
endmodule
